// *** common/ascb_pkg.sv ***
// constants, field layout and decode helpers of the setup configuration bank
package ascb_pkg;

  localparam int NUM_SETUPS   = 8;
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_AIN      = 8;

  // apb geometry: byte address is four times the register index
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 6;

  // register indices
  localparam logic [IDX_W-1:0] CONV_SEL_IDX   = 6'h01;
  localparam logic [IDX_W-1:0] STATUS_IDX     = 6'h02;
  localparam logic [IDX_W-1:0] CHAN_BASE_IDX  = 6'h09;
  localparam logic [IDX_W-1:0] CHAN_LAST_IDX  = 6'h10;
  localparam logic [IDX_W-1:0] SETUP_BASE_IDX = 6'h19;
  localparam logic [IDX_W-1:0] SETUP_LAST_IDX = 6'h20;

  // reset values
  localparam logic [15:0] SETUP_RESET    = 16'h0000;
  localparam logic [3:0]  ROUTE_RESET    = 4'h0;
  localparam logic [2:0]  CHAN_SET_RESET = 3'h0;
  localparam logic [2:0]  ACT_CHAN_RESET = 3'h0;
  localparam logic [7:0]  GAIN_RESET     = 8'h01;

  // setup register fields
  localparam int EXC1_MSB = 15;
  localparam int EXC1_LSB = 13;
  localparam int EXC0_MSB = 12;
  localparam int EXC0_LSB = 10;
  localparam int BURN_MSB = 9;
  localparam int BURN_LSB = 8;
  localparam int BUFP_BIT = 7;
  localparam int BUFM_BIT = 6;
  localparam int REFS_MSB = 5;
  localparam int REFS_LSB = 4;
  localparam int GAIN_MSB = 3;
  localparam int GAIN_LSB = 1;
  localparam int BYP_BIT  = 0;

  // channel register fields
  localparam int ROUTE_MSB = 3;
  localparam int ROUTE_LSB = 0;
  localparam int CSET_MSB  = 6;
  localparam int CSET_LSB  = 4;

  // status register fields
  localparam int ST_CHAN_LSB  = 0;
  localparam int ST_SETUP_LSB = 4;
  localparam int ST_RVALID    = 8;
  localparam int ST_GAIN_LSB  = 16;

  // excitation magnitude code for an idle source
  localparam logic [2:0] EXC_OFF = 3'h0;

  // pin routing codes
  localparam logic [3:0] ROUTE_AIN0 = 4'h0;
  localparam logic [3:0] ROUTE_AIN1 = 4'h1;
  localparam logic [3:0] ROUTE_AIN2 = 4'h4;
  localparam logic [3:0] ROUTE_AIN3 = 4'h5;
  localparam logic [3:0] ROUTE_AIN4 = 4'hA;
  localparam logic [3:0] ROUTE_AIN5 = 4'hB;
  localparam logic [3:0] ROUTE_AIN6 = 4'hE;
  localparam logic [3:0] ROUTE_AIN7 = 4'hF;

  // reserved codes give no pin at all
  function automatic logic [NUM_AIN-1:0] ascb_route_onehot(input logic [3:0] code);
    unique case (code)
      ROUTE_AIN0: ascb_route_onehot = 8'h01;
      ROUTE_AIN1: ascb_route_onehot = 8'h02;
      ROUTE_AIN2: ascb_route_onehot = 8'h04;
      ROUTE_AIN3: ascb_route_onehot = 8'h08;
      ROUTE_AIN4: ascb_route_onehot = 8'h10;
      ROUTE_AIN5: ascb_route_onehot = 8'h20;
      ROUTE_AIN6: ascb_route_onehot = 8'h40;
      ROUTE_AIN7: ascb_route_onehot = 8'h80;
      default:    ascb_route_onehot = 8'h00;
    endcase
  endfunction

endpackage

// *** hdl/ascb_setup_decode.sv ***
// turns one setup word and one routing code into front end controls
`timescale 1ns/1ps
module ascb_setup_decode
  import ascb_pkg::*;
(
  input  wire logic [15:0]        setup_word,
  input  wire logic [3:0]         route_code,
  output logic      [2:0]         exc0_mag,
  output logic      [2:0]         exc1_mag,
  output logic      [1:0]         burnout,
  output logic                    buf_pos,
  output logic                    buf_neg,
  output logic      [1:0]         ref_pair,
  output logic      [7:0]         gain,
  output logic                    bypass,
  output logic      [NUM_AIN-1:0] pin_route
);

  always_comb begin
    exc1_mag = setup_word[EXC1_MSB:EXC1_LSB];
    exc0_mag = setup_word[EXC0_MSB:EXC0_LSB];
    burnout  = setup_word[BURN_MSB:BURN_LSB];
    buf_pos  = setup_word[BUFP_BIT];
    buf_neg  = setup_word[BUFM_BIT];
    ref_pair = setup_word[REFS_MSB:REFS_LSB];
    bypass   = setup_word[BYP_BIT];
    // bypass forces unity gain whatever the code holds
    if (bypass) begin
      gain = 8'h01;
    end else begin
      gain = 8'h01 << setup_word[GAIN_MSB:GAIN_LSB];
    end
    // an idle source is never left hanging on a pin
    if (exc0_mag == EXC_OFF) begin
      pin_route = '0;
    end else begin
      pin_route = ascb_route_onehot(route_code);
    end
  end

endmodule

// *** hdl/ascb_bank.sv ***
// apb register bank of eight setups and per channel excitation routing
`timescale 1ns/1ps
module ascb_bank
  import ascb_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic      [2:0]              excite0_magnitude,
  output logic      [2:0]              excite1_magnitude,
  output logic      [1:0]              burnout_level,
  output logic                         pos_reference_buffer_on,
  output logic                         neg_reference_buffer_on,
  output logic      [1:0]              reference_pair,
  output logic      [7:0]              amp_gain,
  output logic                         amp_bypass,
  output logic      [NUM_AIN-1:0]      excite0_pin_route,
  output logic      [2:0]              active_setup
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_SETUPS-1:0][15:0]  setup;
    logic [NUM_CHANNELS-1:0][3:0] route;
    logic [NUM_CHANNELS-1:0][2:0] chan_setup;
    logic [2:0]                   act_chan;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic [2:0]                   exc0;
    logic [2:0]                   exc1;
    logic [1:0]                   burn;
    logic                         bufp;
    logic                         bufm;
    logic [1:0]                   refp;
    logic [7:0]                   gain;
    logic                         byp;
    logic [NUM_AIN-1:0]           pins;
    logic [2:0]                   act_setup;
  } ascb_state_t;

  ascb_state_t state_reg;
  ascb_state_t state_next;

  logic [IDX_W-1:0]   idx;
  logic               aligned;
  logic               hit_setup;
  logic               hit_chan;
  logic               hit_sel;
  logic               hit_stat;
  logic               mapped;
  logic [2:0]         setup_slot;
  logic [2:0]         chan_slot;
  logic [2:0]         sel_setup;
  logic [15:0]        sel_word;
  logic [3:0]         sel_route;
  logic [2:0]         d_exc0;
  logic [2:0]         d_exc1;
  logic [1:0]         d_burn;
  logic               d_bufp;
  logic               d_bufm;
  logic [1:0]         d_refp;
  logic [7:0]         d_gain;
  logic               d_byp;
  logic [NUM_AIN-1:0] d_pins;
  logic               wr_take;

  // byte lane merge used for the setup registers; channel and select writes take lane 0 only
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign idx        = paddr[ADDR_W-1:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign hit_setup  = aligned && (idx >= SETUP_BASE_IDX) && (idx <= SETUP_LAST_IDX);
  assign hit_chan   = aligned && (idx >= CHAN_BASE_IDX) && (idx <= CHAN_LAST_IDX);
  assign hit_sel    = aligned && (idx == CONV_SEL_IDX);
  assign hit_stat   = aligned && (idx == STATUS_IDX);
  assign mapped     = hit_setup || hit_chan || hit_sel || hit_stat;
  assign setup_slot = 3'(idx - SETUP_BASE_IDX);
  assign chan_slot  = 3'(idx - CHAN_BASE_IDX);
  assign wr_take    = psel && penable && state_reg.pready && pwrite && mapped;

  // the active channel picks its setup, so channels may share one
  assign sel_setup = state_reg.chan_setup[state_reg.act_chan];
  assign sel_word  = state_reg.setup[sel_setup];
  assign sel_route = state_reg.route[state_reg.act_chan];

  ascb_setup_decode u_decode (
    .setup_word (sel_word),
    .route_code (sel_route),
    .exc0_mag   (d_exc0),
    .exc1_mag   (d_exc1),
    .burnout    (d_burn),
    .buf_pos    (d_bufp),
    .buf_neg    (d_bufm),
    .ref_pair   (d_refp),
    .gain       (d_gain),
    .bypass     (d_byp),
    .pin_route  (d_pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    // zero wait: pready rises in the first access cycle, drops after it
    if (psel && !penable) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !mapped;
      state_next.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_setup) begin
          state_next.prdata[15:0] = state_reg.setup[setup_slot];
        end else if (hit_chan) begin
          state_next.prdata[ROUTE_MSB:ROUTE_LSB] = state_reg.route[chan_slot];
          state_next.prdata[CSET_MSB:CSET_LSB]   = state_reg.chan_setup[chan_slot];
        end else if (hit_sel) begin
          state_next.prdata[2:0] = state_reg.act_chan;
        end else if (hit_stat) begin
          state_next.prdata[ST_CHAN_LSB +: 3]  = state_reg.act_chan;
          state_next.prdata[ST_SETUP_LSB +: 3] = state_reg.act_setup;
          state_next.prdata[ST_RVALID]         = |state_reg.pins;
          state_next.prdata[ST_GAIN_LSB +: 8]  = state_reg.gain;
        end
      end
    end else begin
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;
    end
    // writes land only on the completing access edge; status is read only
    if (wr_take) begin
      if (hit_setup) begin
        state_next.setup[setup_slot] =
          16'(lane_merge({16'h0000, state_reg.setup[setup_slot]}, pwdata, pstrb));
      end else if (hit_chan) begin
        if (pstrb[0]) begin
          state_next.route[chan_slot]      = pwdata[ROUTE_MSB:ROUTE_LSB];
          state_next.chan_setup[chan_slot] = pwdata[CSET_MSB:CSET_LSB];
        end
      end else if (hit_sel) begin
        if (pstrb[0]) begin
          state_next.act_chan = pwdata[2:0];
        end
      end
    end
    // front end controls, one cycle behind the registers
    state_next.exc0      = d_exc0;
    state_next.exc1      = d_exc1;
    state_next.burn      = d_burn;
    state_next.bufp      = d_bufp;
    state_next.bufm      = d_bufm;
    state_next.refp      = d_refp;
    state_next.gain      = d_gain;
    state_next.byp       = d_byp;
    state_next.pins      = d_pins;
    state_next.act_setup = sel_setup;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg            <= '0;
      state_reg.setup      <= {NUM_SETUPS{SETUP_RESET}};
      state_reg.route      <= {NUM_CHANNELS{ROUTE_RESET}};
      state_reg.chan_setup <= {NUM_CHANNELS{CHAN_SET_RESET}};
      state_reg.act_chan   <= ACT_CHAN_RESET;
      state_reg.gain       <= GAIN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata                  = state_reg.prdata;
  assign pready                  = state_reg.pready;
  assign pslverr                 = state_reg.pslverr;
  assign excite0_magnitude       = state_reg.exc0;
  assign excite1_magnitude       = state_reg.exc1;
  assign burnout_level           = state_reg.burn;
  assign pos_reference_buffer_on = state_reg.bufp;
  assign neg_reference_buffer_on = state_reg.bufm;
  assign reference_pair          = state_reg.refp;
  assign amp_gain                = state_reg.gain;
  assign amp_bypass              = state_reg.byp;
  assign excite0_pin_route       = state_reg.pins;
  assign active_setup            = state_reg.act_setup;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_setup_write_lands: assert property (
    (wr_take && hit_setup && pstrb == 4'hF) |=>
      state_reg.setup[$past(setup_slot)] == $past(pwdata[15:0]))
    else $error("setup write not stored");

  a_route_ain0: assert property (
    (sel_route == ROUTE_AIN0 && d_exc0 != EXC_OFF) |=> excite0_pin_route == 8'h01)
    else $error("code 0000 did not route to input 0");

  a_route_ain7: assert property (
    (sel_route == ROUTE_AIN7 && d_exc0 != EXC_OFF) |=> excite0_pin_route == 8'h80)
    else $error("code 1111 did not route to input 7");

  a_route_reserved_none: assert property (
    (ascb_route_onehot(sel_route) == 8'h00) |=> excite0_pin_route == 8'h00)
    else $error("reserved routing code drove a pin");

  a_exc1_follows: assert property (
    1'b1 |=> excite1_magnitude == $past(sel_word[EXC1_MSB:EXC1_LSB]))
    else $error("excitation 1 magnitude mismatch");

  a_exc0_off_nopin: assert property (
    (sel_word[EXC0_MSB:EXC0_LSB] == EXC_OFF) |=>
      (excite0_magnitude == EXC_OFF && excite0_pin_route == 8'h00))
    else $error("idle excitation 0 still routed");

  a_burnout_follows: assert property (
    1'b1 |=> burnout_level == $past(sel_word[BURN_MSB:BURN_LSB]))
    else $error("burnout level mismatch");

  a_ref_buffers: assert property (
    1'b1 |=> (pos_reference_buffer_on == $past(sel_word[BUFP_BIT]) &&
              neg_reference_buffer_on == $past(sel_word[BUFM_BIT])))
    else $error("reference buffer enables mismatch");

  a_ref_pair_sel: assert property (
    1'b1 |=> reference_pair == $past(sel_word[REFS_MSB:REFS_LSB]))
    else $error("reference pair mismatch");

  a_gain_power: assert property (
    (!sel_word[BYP_BIT] && sel_word[GAIN_MSB:GAIN_LSB] == 3'h7) |=> amp_gain == 8'h80)
    else $error("gain code 111 is not 128");

  a_gain_bypass_one: assert property (
    sel_word[BYP_BIT] |=> (amp_gain == 8'h01 && amp_bypass))
    else $error("bypass did not force unity gain");

  a_shared_setup: assert property (
    1'b1 |=> active_setup == $past(state_reg.chan_setup[state_reg.act_chan]))
    else $error("active setup not the one the channel selects");

  a_pready_single: assert property (
    pready |=> !pready)
    else $error("pready held for more than one cycle");

  a_unmapped_err: assert property (
    (psel && !penable && !mapped) |=> (pready && pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access did not answer with an error");

  a_setup_readback: assert property (
    (psel && !penable && !pwrite && hit_setup) |=>
      prdata == {16'h0000, $past(state_reg.setup[setup_slot])})
    else $error("setup read data mismatch");

  a_route_ain2: assert property (
    (sel_route == ROUTE_AIN2 && d_exc0 != EXC_OFF) |=> excite0_pin_route == 8'h04)
    else $error("code 0100 did not route to input 2");

  a_route_ain4: assert property (
    (sel_route == ROUTE_AIN4 && d_exc0 != EXC_OFF) |=> excite0_pin_route == 8'h10)
    else $error("code 1010 did not route to input 4");

  a_exc0_follows: assert property (
    1'b1 |=> excite0_magnitude == $past(sel_word[EXC0_MSB:EXC0_LSB]))
    else $error("excitation 0 magnitude mismatch");

  c_setup_write: cover property (wr_take && hit_setup);
  c_gain_max: cover property (amp_gain == 8'h80 && !amp_bypass);
  c_bypass_gain: cover property (amp_bypass && amp_gain == 8'h01);
  c_reserved_route: cover property (d_exc0 != EXC_OFF && d_pins == 8'h00);
  c_unmapped_err: cover property (pready && pslverr);

endmodule

// *** tb/ascb_bank_tb.sv ***
// self-checking apb bench of the setup configuration bank
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ascb_bank_tb;
  import ascb_pkg::*;

  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [ADDR_W-1:0]  paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [3:0]         pstrb = 4'hF;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [2:0]         excite0_magnitude;
  logic [2:0]         excite1_magnitude;
  logic [1:0]         burnout_level;
  logic               pos_reference_buffer_on;
  logic               neg_reference_buffer_on;
  logic [1:0]         reference_pair;
  logic [7:0]         amp_gain;
  logic               amp_bypass;
  logic [NUM_AIN-1:0] excite0_pin_route;
  logic [2:0]         active_setup;
  int                 num_errors = 0;
  int                 cmp_count = 0;
  logic [31:0]        rdat;
  logic               rerr;
  logic [15:0]        w;

  ascb_bank dut_u (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pstrb                   (pstrb),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .excite0_magnitude       (excite0_magnitude),
    .excite1_magnitude       (excite1_magnitude),
    .burnout_level           (burnout_level),
    .pos_reference_buffer_on (pos_reference_buffer_on),
    .neg_reference_buffer_on (neg_reference_buffer_on),
    .reference_pair          (reference_pair),
    .amp_gain                (amp_gain),
    .amp_bypass              (amp_bypass),
    .excite0_pin_route       (excite0_pin_route),
    .active_setup            (active_setup)
  );

  always #12.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready with a bounded count
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(rdat, exp)
    `CHK(rerr, 1'b0)
  endtask

  // front end outputs settle one cycle after the write edge
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  function automatic logic [7:0] exp_route(input logic [3:0] c, input logic [2:0] mag);
    logic [3:0] codes [8];
    codes = '{ROUTE_AIN0, ROUTE_AIN1, ROUTE_AIN2, ROUTE_AIN3,
              ROUTE_AIN4, ROUTE_AIN5, ROUTE_AIN6, ROUTE_AIN7};
    exp_route = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (codes[k] == c && mag != EXC_OFF) exp_route = 8'h01 << k;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(5000 * 25);
    num_errors++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    `CHK(amp_gain, 8'h01)
    `CHK(excite0_magnitude, 3'h0)
    `CHK(excite0_pin_route, 8'h00)
    for (int i = 0; i < 8; i++) begin
      rd_chk(SETUP_BASE_IDX + 6'(i), 32'h0000_0000);
    end
    $display("test reset done");

    // every code of the three bit fields once, bypass held off, each setup selected in turn by channel 0
    for (int i = 0; i < 8; i++) begin
      w = {3'(i), ~3'(i), 2'(i), i[0], i[1], i[2:1], 3'(i), 1'b0};
      apb(1'b1, SETUP_BASE_IDX + 6'(i), {16'hFFFF, w});
      apb(1'b1, CHAN_BASE_IDX, 32'(i) << 4);
      settle();
      rd_chk(SETUP_BASE_IDX + 6'(i), {16'h0000, w});
      `CHK(excite1_magnitude, 3'(i))
      `CHK(excite0_magnitude, ~3'(i))
      `CHK(burnout_level, 2'(i))
      `CHK(pos_reference_buffer_on, i[0])
      `CHK(neg_reference_buffer_on, i[1])
      `CHK(reference_pair, i[2:1])
      `CHK(amp_gain, 8'h01 << i)
      `CHK(amp_bypass, 1'b0)
      `CHK(active_setup, 3'(i))
      `CHK(excite0_pin_route, exp_route(4'h0, ~3'(i)))
    end
    $display("test fields done");

    // bypass overrides the largest gain code
    apb(1'b1, SETUP_BASE_IDX + 6'h02, 32'h0000_000F);
    apb(1'b1, CHAN_BASE_IDX, 32'h0000_0020);
    settle();
    `CHK(amp_gain, 8'h01)
    `CHK(amp_bypass, 1'b1)
    rd_chk(SETUP_BASE_IDX + 6'h02, 32'h0000_000F);
    $display("test bypass done");

    // all sixteen routing codes on channel 5, reserved ones included
    apb(1'b1, SETUP_BASE_IDX + 6'h01, 32'h0000_0400);
    apb(1'b1, CONV_SEL_IDX, 32'h0000_0005);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, CHAN_BASE_IDX + 6'h05, 32'h0000_0010 | 32'(c));
      settle();
      `CHK(excite0_pin_route, exp_route(4'(c), 3'h1))
      rd_chk(CHAN_BASE_IDX + 6'h05, 32'h0000_0010 | 32'(c));
    end
    $display("test routing done");

    // two channels share setup 6
    apb(1'b1, SETUP_BASE_IDX + 6'h06, 32'h0000_A8B2);
    apb(1'b1, CHAN_BASE_IDX + 6'h02, 32'h0000_0061);
    apb(1'b1, CHAN_BASE_IDX + 6'h06, 32'h0000_006E);
    apb(1'b1, CONV_SEL_IDX, 32'h0000_0002);
    settle();
    `CHK(active_setup, 3'h6)
    `CHK(excite1_magnitude, 3'h5)
    `CHK(excite0_pin_route, 8'h02)
    apb(1'b1, CONV_SEL_IDX, 32'h0000_0006);
    settle();
    `CHK(active_setup, 3'h6)
    `CHK(amp_gain, 8'h02)
    `CHK(excite0_pin_route, 8'h40)
    rd_chk(CONV_SEL_IDX, 32'h0000_0006);
    rd_chk(STATUS_IDX, 32'h0002_0166);
    $display("test sharing done");

    // unmapped places answer with an error and leave setups alone
    apb(1'b0, 6'h3F, 32'h0000_0000);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0000_0000)
    apb(1'b1, 6'h11, 32'h0000_FFFF);
    `CHK(rerr, 1'b1)
    rd_chk(SETUP_BASE_IDX + 6'h07, 32'h0000_0000 | {16'h0000, 3'h7, 3'h0, 2'h3, 1'b1, 1'b1,
           2'h3, 3'h7, 1'b0});
    $display("test unmapped done");

    // only the strobed byte lane of a setup changes
    pstrb <= 4'h1;
    apb(1'b1, SETUP_BASE_IDX + 6'h03, 32'h0000_FFFF);
    pstrb <= 4'hF;
    rd_chk(SETUP_BASE_IDX + 6'h03, 32'h0000_73FF);
    $display("test strobe done");
    final_report();
  end
endmodule
